/* hdl/ext_offset_pkg.sv */
`default_nettype none
package ext_offset_pkg;

  // widths of the data space, the pointers and the program counter
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned PC_W   = 21;
  localparam int unsigned BANK_W = 4;
  localparam int unsigned LIT_W  = 6;
  localparam int unsigned NUM_PTR = 3;

  // opcode field layout
  localparam int unsigned OP_HI_MSB  = 15;
  localparam int unsigned OP_HI_LSB  = 8;
  localparam int unsigned SEL_MSB    = 7;
  localparam int unsigned SEL_LSB    = 6;
  localparam int unsigned LIT_MSB    = 5;
  localparam int unsigned ACCESS_BIT = 8;
  localparam int unsigned FILE_MSB   = 7;

  // pointer-subtract opcode upper byte and the select value meaning subtract-and-return
  localparam logic [7:0] SUB_PTR_OPCODE = 8'he9;
  localparam logic [1:0] SEL_RETURN     = 2'h3;
  localparam logic [1:0] SEL_FRAME      = 2'h2;

  // highest file operand that becomes a frame-pointer offset
  localparam logic [7:0] OFFSET_MAX = 8'h5f;
  // access bank high part sits at the top of the data space
  localparam logic [3:0] ACCESS_HI_BANK = 4'hf;
  localparam logic [3:0] ACCESS_LO_BANK = 4'h0;

  // reset values
  localparam logic [ADDR_W-1:0] PTR_RESET = 12'h000;
  localparam logic [PC_W-1:0]   PC_RESET  = 21'h000000;

  typedef struct packed {
    logic        valid;    // one instruction cycle offered
    logic        file_op;  // byte- or bit-oriented instruction carrying the access bit
    logic [15:0] opcode;
  } instr_s;

  typedef struct packed {
    logic              en;
    logic [1:0]        sel;
    logic [ADDR_W-1:0] val;
  } ptr_wr_s;

  typedef struct packed {
    logic [ADDR_W-1:0] p2;
    logic [ADDR_W-1:0] p1;
    logic [ADDR_W-1:0] p0;
  } ptr_set_s;

  typedef struct packed {
    logic              valid;
    logic              indexed;
    logic [ADDR_W-1:0] addr;
  } data_addr_s;

  typedef struct packed {
    logic            valid;
    logic [PC_W-1:0] addr;
  } pc_load_s;

  // plain address of a file operand with no pointer offsetting
  function automatic logic [ADDR_W-1:0] std_addr(input logic [7:0] f, input logic a,
                                                 input logic [BANK_W-1:0] bank);
    logic [ADDR_W-1:0] r;
    r = {bank, f};
    if (!a) begin
      r = (f > OFFSET_MAX) ? {ACCESS_HI_BANK, f} : {ACCESS_LO_BANK, f};
    end
    return r;
  endfunction

  // operand falls into the indexed window
  function automatic logic is_indexed(input logic ext, input logic a, input logic [7:0] f);
    return ext && !a && (f <= OFFSET_MAX);
  endfunction

endpackage
`default_nettype wire

/* hdl/offset_addr_calc.sv */
`timescale 1ns/1ps
`default_nettype none
module offset_addr_calc (
  input  wire logic                                 ext_en_i,
  input  wire logic                                 access_i,
  input  wire logic [7:0]                           file_i,
  input  wire logic [ext_offset_pkg::BANK_W-1:0]    bank_i,
  input  wire logic [ext_offset_pkg::ADDR_W-1:0]    frame_ptr_i,
  output logic      [ext_offset_pkg::ADDR_W-1:0]    addr_o,
  output logic                                      indexed_o
);
  import ext_offset_pkg::*;

  wire logic [ADDR_W-1:0] plain_addr;
  wire logic [ADDR_W-1:0] offset_addr;

  // offset from the frame pointer wraps within the 4 KiB space; pointer 00h gives the low access bank
  assign offset_addr = frame_ptr_i + {4'h0, file_i};
  assign plain_addr  = std_addr(file_i, access_i, bank_i);
  assign indexed_o   = is_indexed(ext_en_i, access_i, file_i);
  assign addr_o      = indexed_o ? offset_addr : plain_addr;
endmodule
`default_nettype wire

/* hdl/extended_fsr_offset_decode.sv */
// Contract
// - opcode E9h with a pointer select and a six-bit literal subtracts the literal from the chosen pointer.
// - select value 11 means subtract-and-return, acting only on the stack frame pointer.
// - subtract-and-return then loads the program counter from the top of the return stack.
// - subtract-and-return takes two instruction cycles, the second doing nothing.
// - enabling the extended set also enables indexed literal offset addressing.
// - with the extension off the file operand is a plain access bank or banked address.
// - with the extension on and access bit 0, operands up to 5Fh are offsets from the frame pointer.
// - the offsetting applies to every byte- and bit-oriented instruction.
// - a frame pointer of 00h gives the original low access bank addresses.
// - pointer plus offset reaches the whole 000h to FFFh data space.
`timescale 1ns/1ps
`default_nettype none
module extended_fsr_offset_decode (
  input  wire logic                                     ref_clk_i,
  input  wire logic                                     rst_n_i,
  input  wire logic                                     ext_set_en_i,
  input  wire ext_offset_pkg::instr_s                   instr_i,
  input  wire logic [ext_offset_pkg::BANK_W-1:0]        bank_select_register_i,
  input  wire logic [ext_offset_pkg::PC_W-1:0]          top_of_return_stack_i,
  input  wire ext_offset_pkg::ptr_wr_s                  ptr_wr_i,
  output var  ext_offset_pkg::ptr_set_s                 indirect_pointer_o,
  output var  ext_offset_pkg::data_addr_s               data_addr_o,
  output var  ext_offset_pkg::pc_load_s                 program_counter_o,
  output logic                                          busy_o
);
  import ext_offset_pkg::*;

  typedef enum logic {ST_EXEC, ST_NOP} cyc_state_e;

  cyc_state_e             state_ff;
  cyc_state_e             nxt_state;
  logic [ADDR_W-1:0]      ptr_ff [NUM_PTR];
  logic [ADDR_W-1:0]      nxt_ptr [NUM_PTR];
  data_addr_s             addr_ff;
  data_addr_s             nxt_addr;
  pc_load_s               pc_ff;
  pc_load_s               nxt_pc;
  logic                   busy_ff;

  // subtract a six-bit literal from a pointer, wrapping in the data space
  function automatic logic [ADDR_W-1:0] sub_lit(input logic [ADDR_W-1:0] p, input logic [LIT_W-1:0] k);
    return p - {6'h00, k};
  endfunction

  // opcode field decode
  wire logic              take;
  wire logic              is_sub;
  wire logic              is_ret;
  wire logic              is_ptr_sub;
  wire logic [1:0]        dec_sel;
  wire logic [1:0]        tgt_sel;
  wire logic [LIT_W-1:0]  lit_k;
  wire logic [7:0]        file_f;
  wire logic              access_a;
  wire logic [ADDR_W-1:0] sel_ptr;
  wire logic [ADDR_W-1:0] sub_result;
  wire logic [ADDR_W-1:0] calc_addr;
  wire logic              calc_indexed;

  assign take       = instr_i.valid && (state_ff == ST_EXEC);
  assign is_sub     = take && ext_set_en_i && (instr_i.opcode[OP_HI_MSB:OP_HI_LSB] == SUB_PTR_OPCODE);
  assign dec_sel    = instr_i.opcode[SEL_MSB:SEL_LSB];
  assign is_ret     = is_sub && (dec_sel == SEL_RETURN);
  assign is_ptr_sub = is_sub && !is_ret;
  assign tgt_sel    = (dec_sel == SEL_RETURN) ? SEL_FRAME : dec_sel;
  assign lit_k      = instr_i.opcode[LIT_MSB:0];
  assign file_f     = instr_i.opcode[FILE_MSB:0];
  assign access_a   = instr_i.opcode[ACCESS_BIT];
  assign sel_ptr    = ptr_ff[tgt_sel];
  assign sub_result = sub_lit(sel_ptr, lit_k);

  // effective address of the file operand
  offset_addr_calc u_calc (
    .ext_en_i    (ext_set_en_i),
    .access_i    (access_a),
    .file_i      (file_f),
    .bank_i      (bank_select_register_i),
    .frame_ptr_i (ptr_ff[SEL_FRAME]),
    .addr_o      (calc_addr),
    .indexed_o   (calc_indexed)
  );

  // next pointer values: subtract wins over an outside load; nothing changes in the idle cycle
  always_comb begin
    for (int i = 0; i < NUM_PTR; i++) begin
      nxt_ptr[i] = ptr_ff[i];
      if (state_ff == ST_EXEC && ptr_wr_i.en && ptr_wr_i.sel == i[1:0]) begin
        nxt_ptr[i] = ptr_wr_i.val;
      end
      if (is_sub && tgt_sel == i[1:0]) begin
        nxt_ptr[i] = sub_result;
      end
    end
  end

  // address, return and cycle control
  always_comb begin
    nxt_addr         = '0;
    nxt_addr.valid   = take && instr_i.file_op;
    nxt_addr.indexed = nxt_addr.valid && calc_indexed;
    nxt_addr.addr    = nxt_addr.valid ? calc_addr : addr_ff.addr;
    nxt_pc.valid     = is_ret;
    nxt_pc.addr      = is_ret ? top_of_return_stack_i : pc_ff.addr;
    case (state_ff)
      ST_EXEC: nxt_state = is_ret ? ST_NOP : ST_EXEC;
      ST_NOP:  nxt_state = ST_EXEC;
      default: nxt_state = ST_EXEC;
    endcase
  end

  // state registers
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < NUM_PTR; i++) begin
        ptr_ff[i] <= PTR_RESET;
      end
      state_ff <= ST_EXEC;
      busy_ff  <= 1'b0;
      addr_ff  <= '0;
      pc_ff    <= '{valid: 1'b0, addr: PC_RESET};
    end else begin
      ptr_ff   <= nxt_ptr;
      state_ff <= nxt_state;
      busy_ff  <= (nxt_state == ST_NOP);
      addr_ff  <= nxt_addr;
      pc_ff    <= nxt_pc;
    end
  end

  // outputs come straight from the registers
  assign indirect_pointer_o = '{p2: ptr_ff[2], p1: ptr_ff[1], p0: ptr_ff[0]};
  assign data_addr_o        = addr_ff;
  assign program_counter_o  = pc_ff;
  assign busy_o             = busy_ff;

  // checks
  wire logic [ADDR_W-1:0] frame_ptr;
  wire logic              file_take;
  assign frame_ptr = ptr_ff[SEL_FRAME];
  assign file_take = take && instr_i.file_op;

  sequence s_ret_issue;
    is_ret;
  endsequence

  sequence s_nop_cycle;
    busy_o ##1 !busy_o && !program_counter_o.valid && !data_addr_o.valid;
  endsequence

  property p_ptr_sub;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      is_ptr_sub |=> ptr_ff[$past(tgt_sel)] == $past(sel_ptr) - {6'h00, $past(lit_k)};
  endproperty
  a_ptr_sub: assert property (p_ptr_sub) else $error("pointer subtract result wrong");

  property p_ret_frame_only;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      s_ret_issue |=> $stable(ptr_ff[0]) && $stable(ptr_ff[1]) && $changed(frame_ptr) == ($past(lit_k) != 6'h00);
  endproperty
  a_ret_frame_only: assert property (p_ret_frame_only) else $error("return touched the wrong pointer");

  property p_ret_pc;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      s_ret_issue |=> program_counter_o.valid && program_counter_o.addr == $past(top_of_return_stack_i);
  endproperty
  a_ret_pc: assert property (p_ret_pc) else $error("return did not load the stack top");

  property p_two_cycles;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      s_ret_issue ##1 1'b1 |-> s_nop_cycle and ##1 $stable(ptr_ff[0]) && $stable(ptr_ff[1]) && $stable(frame_ptr);
  endproperty
  a_two_cycles: assert property (p_two_cycles) else $error("second return cycle was not idle");

  // the idle cycle of a return refuses whatever is offered in it
  property p_idle_refuses;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      busy_o |=> $stable(ptr_ff[0]) && $stable(ptr_ff[1]) && $stable(frame_ptr) &&
        !data_addr_o.valid && !program_counter_o.valid;
  endproperty
  a_idle_refuses: assert property (p_idle_refuses) else $error("instruction taken in the idle cycle");

  // with the extension off the subtract opcode leaves the pointers and the program counter alone
  property p_sub_needs_ext;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      take && !ext_set_en_i && instr_i.opcode[OP_HI_MSB:OP_HI_LSB] == SUB_PTR_OPCODE && !ptr_wr_i.en |=>
        $stable(ptr_ff[0]) && $stable(ptr_ff[1]) && $stable(frame_ptr) && !program_counter_o.valid;
  endproperty
  a_sub_needs_ext: assert property (p_sub_needs_ext) else $error("subtract decoded with the extension off");

  property p_std_addr;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      file_take && !ext_set_en_i |=> data_addr_o.valid && !data_addr_o.indexed &&
        data_addr_o.addr == std_addr($past(file_f), $past(access_a), $past(bank_select_register_i));
  endproperty
  a_std_addr: assert property (p_std_addr) else $error("standard address wrong");

  property p_indexed;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      file_take && ext_set_en_i && !access_a && file_f <= OFFSET_MAX |=>
        data_addr_o.indexed && data_addr_o.addr == $past(frame_ptr) + {4'h0, $past(file_f)};
  endproperty
  a_indexed: assert property (p_indexed) else $error("indexed address wrong");

  property p_any_file_op;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      file_take |=> data_addr_o.valid &&
        data_addr_o.indexed == $past(ext_set_en_i && !access_a && file_f <= OFFSET_MAX);
  endproperty
  a_any_file_op: assert property (p_any_file_op) else $error("offset mode not applied");

  property p_zero_frame;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      file_take && ext_set_en_i && !access_a && file_f <= OFFSET_MAX && frame_ptr == 12'h000 |=>
        data_addr_o.addr == {4'h0, $past(file_f)};
  endproperty
  a_zero_frame: assert property (p_zero_frame) else $error("zero frame pointer did not give legacy address");

  property p_ext_plain;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      file_take && ext_set_en_i && (access_a || file_f > OFFSET_MAX) |=> !data_addr_o.indexed &&
        data_addr_o.addr == std_addr($past(file_f), $past(access_a), $past(bank_select_register_i));
  endproperty
  a_ext_plain: assert property (p_ext_plain) else $error("plain operand was offset");

  property p_wrap;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      file_take && ext_set_en_i && !access_a && file_f <= OFFSET_MAX && frame_ptr > 12'hfa0 |=>
        data_addr_o.addr >= $past(frame_ptr) || data_addr_o.addr < 12'h060;
  endproperty
  a_wrap: assert property (p_wrap) else $error("offset address left the data space");
endmodule
`default_nettype wire

/* sim/extended_fsr_offset_decode_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin err_total++; \
  $display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); end end
module extended_fsr_offset_decode_tb;
  import ext_offset_pkg::*;

  logic                ref_clk_i;
  logic                rst_n_i;
  logic                ext_set_en_i;
  instr_s              instr_i;
  logic [BANK_W-1:0]   bank_select_register_i;
  logic [PC_W-1:0]     top_of_return_stack_i;
  ptr_wr_s             ptr_wr_i;
  ptr_set_s            ptr_o;
  data_addr_s          da_o;
  pc_load_s            pc_o;
  logic                busy_o;
  ptr_set_s            s_ptr;
  data_addr_s          s_da;
  pc_load_s            s_pc;
  logic                s_busy;
  int                  err_total;
  int                  checks_done;

  extended_fsr_offset_decode u_extended_fsr_offset_decode (
    .ref_clk_i              (ref_clk_i),
    .rst_n_i                (rst_n_i),
    .ext_set_en_i           (ext_set_en_i),
    .instr_i                (instr_i),
    .bank_select_register_i (bank_select_register_i),
    .top_of_return_stack_i  (top_of_return_stack_i),
    .ptr_wr_i               (ptr_wr_i),
    .indirect_pointer_o     (ptr_o),
    .data_addr_o            (da_o),
    .program_counter_o      (pc_o),
    .busy_o                 (busy_o)
  );

  // 200 MHz core clock
  initial begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end

  // verdict and end of run
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // pointer-subtract opcode word
  function automatic logic [15:0] sub_op(input logic [1:0] sel, input logic [5:0] k);
    return {SUB_PTR_OPCODE, sel, k};
  endfunction

  // expected effective address of a file operand
  function automatic logic [ADDR_W-1:0] ref_addr(input logic ext, input logic [15:0] op,
                                                 input logic [ADDR_W-1:0] p2, input logic [3:0] b);
    if (op[8]) return {b, op[7:0]};
    if (ext && op[7:0] <= 8'h5f) return p2 + {4'h0, op[7:0]};
    return {(op[7:0] > 8'h5f) ? 4'hf : 4'h0, op[7:0]};
  endfunction

  // outside pointer load, one-cycle pulse
  task automatic load_ptr(input logic [1:0] sel, input logic [ADDR_W-1:0] val);
    @(posedge ref_clk_i);
    ptr_wr_i <= {1'b1, sel, val};
    @(posedge ref_clk_i);
    ptr_wr_i <= '0;
    #1;
  endtask

  // one instruction, optionally followed back to back by a second; snapshot after the first
  task automatic go(input logic ext, input logic fop, input logic [15:0] op,
                    input logic [15:0] op2, input logic v2);
    @(posedge ref_clk_i);
    ext_set_en_i <= ext;
    instr_i      <= {1'b1, fop, op};
    @(posedge ref_clk_i);
    instr_i <= {v2, 1'b0, op2};
    #1;
    s_ptr  = ptr_o;
    s_da   = da_o;
    s_pc   = pc_o;
    s_busy = busy_o;
    @(posedge ref_clk_i);
    instr_i <= '0;
    #1;
  endtask

  // file operand addressing with a given frame pointer and bank
  task automatic addr_case(input logic ext, input logic [15:0] op,
                           input logic [ADDR_W-1:0] p2, input logic [3:0] b);
    load_ptr(2'h2, p2);
    @(posedge ref_clk_i);
    bank_select_register_i <= b;
    go(ext, 1'b1, op, 16'h0000, 1'b0);
    `CHK(s_da.valid, 1'b1)
    `CHK(s_da.addr, ref_addr(ext, op, p2, b))
    `CHK(s_da.indexed, ext & ~op[8] & (op[7:0] <= 8'h5f))
  endtask

  // hang guard
  initial begin
    #100000;
    err_total++;
    tally_and_finish();
  end

  // main sequence
  initial begin
    err_total = 0;
    checks_done = 0;
    rst_n_i = 1'b0;
    ext_set_en_i = 1'b0;
    instr_i = '0;
    bank_select_register_i = 4'h0;
    top_of_return_stack_i = 21'h000000;
    ptr_wr_i = '0;
    repeat (8) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    #1;
    `CHK(ptr_o, 36'h000000000)
    `CHK({da_o.valid, pc_o.valid, busy_o}, 3'h0)
    // pointer subtraction on each pointer, with wrap and back to back
    load_ptr(2'h0, 12'h123);
    load_ptr(2'h1, 12'h010);
    load_ptr(2'h2, 12'h3ff);
    go(1'b1, 1'b0, sub_op(2'h0, 6'h3f), 16'h0000, 1'b0);
    `CHK(s_ptr.p0, 12'h0e4)
    `CHK(s_da.valid, 1'b0)
    go(1'b1, 1'b0, sub_op(2'h1, 6'h20), 16'h0000, 1'b0);
    `CHK(s_ptr.p1, 12'hff0)
    go(1'b1, 1'b0, sub_op(2'h2, 6'h23), 16'h0000, 1'b0);
    `CHK(ptr_o.p2, 12'h3dc)
    go(1'b1, 1'b0, sub_op(2'h0, 6'h01), sub_op(2'h0, 6'h02), 1'b1);
    `CHK(ptr_o.p0, 12'h0e1)
    go(1'b0, 1'b0, sub_op(2'h0, 6'h01), 16'h0000, 1'b0);
    `CHK(ptr_o.p0, 12'h0e1)
    // subtract-and-return with a refused instruction in its idle cycle
    @(posedge ref_clk_i);
    top_of_return_stack_i <= 21'h1abcd;
    go(1'b1, 1'b0, sub_op(SEL_RETURN, 6'h05), sub_op(2'h0, 6'h01), 1'b1);
    `CHK(s_ptr.p2, 12'h3d7)
    `CHK(s_ptr.p0, 12'h0e1)
    `CHK(s_pc.valid, 1'b1)
    `CHK(s_pc.addr, 21'h1abcd)
    `CHK(s_busy, 1'b1)
    `CHK(ptr_o.p0, 12'h0e1)
    `CHK(ptr_o.p2, 12'h3d7)
    `CHK({busy_o, pc_o.valid}, 2'h0)
    // operand addressing, extension off and on, byte and bit instructions
    addr_case(1'b0, 16'h2405, 12'h3dc, 4'h3);
    addr_case(1'b0, 16'h2480, 12'h3dc, 4'h3);
    addr_case(1'b0, 16'h2505, 12'h3dc, 4'h3);
    addr_case(1'b1, 16'h242c, 12'ha00, 4'h3);
    addr_case(1'b1, 16'h8e5f, 12'h100, 4'h3);
    addr_case(1'b1, 16'h6860, 12'h100, 4'h3);
    addr_case(1'b1, 16'h6905, 12'h100, 4'h2);
    addr_case(1'b1, 16'h0250, 12'hfff, 4'h0);
    addr_case(1'b1, 16'h0010, 12'h000, 4'h0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
